/* inc/hpf_pkg.sv */
// Purpose: shared constants of the hall period frequency estimator
// Assumes: 25 MHz system clock
// Notes: times kept in their own units, cycle counts derived from them
package hpf_pkg;
  // ----------------------------------------------------------------
  // clock and time base
  // ----------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 40;
  localparam int RES_TICK_NS = 16000;
  localparam int RES_TICK_CYCLES = (RES_TICK_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int MS_TICK_NS = 1000000;
  localparam int MS_TICK_CYCLES = (MS_TICK_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int RES_CNT_W = 9;
  localparam int MS_PRE_W = 16;
  // ----------------------------------------------------------------
  // measurement and conversion
  // ----------------------------------------------------------------
  localparam int PERIOD_W = 16;
  localparam int FREQ_W = 18;
  localparam int SUM_W = 20;
  localparam int DIV_STEP_W = 5;
  localparam logic [FREQ_W-1:0] FREQ_DIVIDEND = 18'h3FFFF;
  localparam logic [PERIOD_W-1:0] PERIOD_MAX = 16'hFFFF;
  localparam logic [PERIOD_W-1:0] HALF_MS_LIMIT = 16'h0418;
  localparam int HIST_DEPTH = 4;
  localparam logic [2:0] HIST_FULL = 3'h4;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [FREQ_W-1:0] FREQ_INIT_VALUE = 18'h00100;
  localparam logic [FREQ_W-1:0] FREQ_RESET = 18'h00000;
  localparam logic [PERIOD_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [DIV_STEP_W-1:0] DIV_STEPS = 5'h12;
endpackage

/* rtl/hpf_divider.sv */
// Purpose: sequential restoring divider, one quotient bit per clock
// Assumes: divisor is never zero when start is raised
// Notes: start is ignored while busy
`timescale 1ns/100ps
module hpf_divider (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // request
  input wire logic start,
  input wire logic [hpf_pkg::FREQ_W-1:0] dividend,
  input wire logic [hpf_pkg::PERIOD_W-1:0] divisor,
  // answer
  output logic busy,
  output logic done,
  output logic [hpf_pkg::FREQ_W-1:0] quotient
);
  typedef struct packed {
    logic busy;
    logic done;
    logic [hpf_pkg::DIV_STEP_W-1:0] step;
    logic [hpf_pkg::PERIOD_W:0] rem;
    logic [hpf_pkg::FREQ_W-1:0] q;
    logic [hpf_pkg::PERIOD_W-1:0] dvs;
  } hpf_div_state_t;

  hpf_div_state_t st;
  hpf_div_state_t next_st;
  logic [hpf_pkg::PERIOD_W:0] trial;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    trial = {st.rem[hpf_pkg::PERIOD_W-1:0], st.q[hpf_pkg::FREQ_W-1]};
    if (st.busy) begin
      next_st.q = {st.q[hpf_pkg::FREQ_W-2:0], 1'b0};
      if (trial >= {1'b0, st.dvs}) begin
        next_st.rem = trial - {1'b0, st.dvs};
        next_st.q[0] = 1'b1;
      end else begin
        next_st.rem = trial;
      end
      next_st.step = st.step - 5'h01;
      if (st.step == 5'h01) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
    end else if (start) begin
      next_st.busy = 1'b1;
      next_st.step = hpf_pkg::DIV_STEPS;
      next_st.rem = '0;
      next_st.q = dividend;
      next_st.dvs = divisor;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy = st.busy;
  assign done = st.done;
  assign quotient = st.q;
endmodule

/* rtl/hpf_estimator.sv */
// Purpose: stator frequency estimate from one rotor position sensor
// Assumes: sensor pin asynchronous to clock, 25 MHz clock
// Notes: one estimate per captured sensor edge, i.e. two per sensor period
//
// Behaviour
// - until a valid half-period has been measured the output shows the initialization value.
// - from the first to the third valid measurement the output shows the latest single result.
// - from the fourth measurement on the output shows the mean of the last four results.
// - one output bit stands for 0.1192 Hz of electrical frequency.
// - each half-period is turned into frequency as 0x3FFFF divided by the period count.
// - the half-period count is an unsigned 16-bit value counting 16 us units.
// - the result equals mechanical rpm times pole pairs over 60.
// - a millisecond tick is made from a free counter overflow every 1 ms.
// - each millisecond tick advances a period-side count and a free millisecond count.
// - a half-period is captured on each settled edge after the first, unless its count is zero or its gap too long.
// - the estimate is recomputed once per captured half-period, so twice per full sensor period when both halves are captured.
`timescale 1ns/100ps
module hpf_estimator #(
  parameter int MS_TICK_CYCLES = hpf_pkg::MS_TICK_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // position sensor
  input wire logic sensorIn,
  // estimate
  output logic [hpf_pkg::FREQ_W-1:0] statorFreq,
  output logic freqUpdate,
  output logic [2:0] measCount,
  // time base
  output logic millisecondTick,
  output logic [hpf_pkg::PERIOD_W-1:0] millisecondTimeCount,
  output logic [hpf_pkg::PERIOD_W-1:0] halfPeriod
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic syncA;
    logic syncB;
    logic syncC;
    logic level;
    logic haveEdge;
    logic [hpf_pkg::RES_CNT_W-1:0] resCnt;
    logic [hpf_pkg::MS_PRE_W-1:0] msPre;
    logic msTick;
    logic [hpf_pkg::PERIOD_W-1:0] period;
    logic [hpf_pkg::PERIOD_W-1:0] msInPeriod;
    logic [hpf_pkg::PERIOD_W-1:0] msTime;
    logic [hpf_pkg::PERIOD_W-1:0] lastPeriod;
    logic divStart;
    logic [hpf_pkg::PERIOD_W-1:0] divisor;
    logic [hpf_pkg::HIST_DEPTH-1:0][hpf_pkg::FREQ_W-1:0] hist;
    logic [2:0] count;
    logic [hpf_pkg::FREQ_W-1:0] freq;
    logic update;
  } hpf_state_t;

  localparam logic [hpf_pkg::RES_CNT_W-1:0] RES_LAST = 9'(hpf_pkg::RES_TICK_CYCLES - 1);
  localparam logic [hpf_pkg::MS_PRE_W-1:0] MS_LAST = 16'(MS_TICK_CYCLES - 1);

  localparam hpf_state_t STATE_RESET = '{
    syncA: 1'b0,
    syncB: 1'b0,
    syncC: 1'b0,
    level: 1'b0,
    haveEdge: 1'b0,
    resCnt: '0,
    msPre: '0,
    msTick: 1'b0,
    period: hpf_pkg::COUNT_RESET,
    msInPeriod: hpf_pkg::COUNT_RESET,
    msTime: hpf_pkg::COUNT_RESET,
    lastPeriod: hpf_pkg::COUNT_RESET,
    divStart: 1'b0,
    divisor: hpf_pkg::COUNT_RESET,
    hist: '0,
    count: 3'h0,
    freq: hpf_pkg::FREQ_INIT_VALUE,
    update: 1'b0
  };

  hpf_state_t st;
  hpf_state_t next_st;

  logic divBusy;
  logic divDone;
  logic [hpf_pkg::FREQ_W-1:0] divQuot;

  // ----------------------------------------------------------------
  // period to frequency division
  // ----------------------------------------------------------------
  // scaling: 16 us units into 0x3FFFF gives 0.1192 Hz per bit
  hpf_divider hpf_divider_inst (
    .clock(clock),
    .rstn(rstn),
    .start(st.divStart),
    .dividend(hpf_pkg::FREQ_DIVIDEND),
    .divisor(st.divisor),
    .busy(divBusy),
    .done(divDone),
    .quotient(divQuot)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic edgeSeen;
  logic periodOk;
  logic resTick;
  logic [2:0] newCount;
  logic [hpf_pkg::SUM_W-1:0] sum;
  logic [hpf_pkg::HIST_DEPTH-1:0][hpf_pkg::FREQ_W-1:0] newHist;

  always_comb begin
    next_st = st;
    next_st.divStart = 1'b0;
    next_st.update = 1'b0;
    next_st.msTick = 1'b0;
    newCount = st.count;
    newHist = st.hist;
    sum = '0;

    // three-stage synchroniser, a change counts once stages two and three agree
    next_st.syncA = sensorIn;
    next_st.syncB = st.syncA;
    next_st.syncC = st.syncB;
    edgeSeen = (st.syncB == st.syncC) && (st.syncC != st.level);
    if (st.syncB == st.syncC) begin
      next_st.level = st.syncC;
    end

    // 1 ms tick from the prescaler overflow
    if (st.msPre == MS_LAST) begin
      next_st.msPre = '0;
      next_st.msTick = 1'b1;
    end else begin
      next_st.msPre = st.msPre + 16'h0001;
    end
    if (st.msTick) begin
      next_st.msTime = st.msTime + 16'h0001;
      if (st.msInPeriod != hpf_pkg::PERIOD_MAX) begin
        next_st.msInPeriod = st.msInPeriod + 16'h0001;
      end
    end

    // 16 us resolution counter for the half-period
    resTick = (st.resCnt == RES_LAST);
    if (resTick) begin
      next_st.resCnt = '0;
      if (st.period != hpf_pkg::PERIOD_MAX) begin
        next_st.period = st.period + 16'h0001;
      end
    end else begin
      next_st.resCnt = st.resCnt + 9'h001;
    end

    // capture on a settled edge; too long a gap or a zero count is discarded
    // the millisecond count guards against a half-period past 16 bits
    periodOk = st.haveEdge && (st.period != hpf_pkg::COUNT_RESET)
      && (st.msInPeriod <= hpf_pkg::HALF_MS_LIMIT);
    if (edgeSeen) begin
      next_st.haveEdge = 1'b1;
      next_st.period = hpf_pkg::COUNT_RESET;
      next_st.resCnt = '0;
      next_st.msInPeriod = hpf_pkg::COUNT_RESET;
      if (periodOk && !divBusy) begin
        next_st.lastPeriod = st.period;
        next_st.divisor = st.period;
        next_st.divStart = 1'b1;
      end
    end

    // fold a new result into the history
    if (divDone) begin
      for (int i = hpf_pkg::HIST_DEPTH - 1; i > 0; i--) begin
        newHist[i] = st.hist[i-1];
      end
      newHist[0] = divQuot;
      if (st.count != hpf_pkg::HIST_FULL) begin
        newCount = st.count + 3'h1;
      end
      for (int i = 0; i < hpf_pkg::HIST_DEPTH; i++) begin
        sum = sum + {2'b00, newHist[i]};
      end
      next_st.hist = newHist;
      next_st.count = newCount;
      next_st.update = 1'b1;
      if (newCount == hpf_pkg::HIST_FULL) begin
        next_st.freq = sum[hpf_pkg::SUM_W-1:2];
      end else begin
        next_st.freq = divQuot;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // reset value of freq is the initialization value
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign statorFreq = st.freq;
  assign freqUpdate = st.update;
  assign measCount = st.count;
  assign millisecondTick = st.msTick;
  assign millisecondTimeCount = st.msTime;
  assign halfPeriod = st.lastPeriod;
endmodule

/* verification/hpf_sensor_model.sv */
// Purpose: rotor position sensor, one level change per request
// Assumes: request held until ack
// Notes: push-pull output, so the level always stands
`timescale 1ns/100ps
module hpf_sensor_model (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // request from bench
  input wire logic req,
  input wire logic [19:0] gap,
  output logic ack,
  // sensor pin
  output logic sensorIn
);
  logic [19:0] cnt;
  logic busy;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sensorIn <= 1'b0;
      cnt <= 20'h0;
      ack <= 1'b0;
      busy <= 1'b0;
    end else begin
      ack <= 1'b0;
      if (!busy && req) begin
        busy <= 1'b1;
        cnt <= gap;
      end else if (busy) begin
        if (cnt <= 20'h1) begin
          sensorIn <= ~sensorIn;
          busy <= 1'b0;
          ack <= 1'b1;
        end else begin
          cnt <= cnt - 20'h1;
        end
      end
    end
  end
endmodule

/* verification/hpf_checker_sva.sv */
// Purpose: port assertions of the estimator
// Assumes: one clock domain
// Notes: result history rebuilt from halfPeriod
`timescale 1ns/100ps
module hpf_checker #(parameter int MS_TICK_CYCLES = 50) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // ports watched
  input wire logic sensorIn,
  input wire logic [hpf_pkg::FREQ_W-1:0] statorFreq,
  input wire logic freqUpdate,
  input wire logic [2:0] measCount,
  input wire logic millisecondTick,
  input wire logic [hpf_pkg::PERIOD_W-1:0] millisecondTimeCount,
  input wire logic [hpf_pkg::PERIOD_W-1:0] halfPeriod
);
  logic [17:0] h1, h2, h3, res;
  logic [19:0] sum;
  logic [15:0] gap;
  logic [7:0] sinceEdge;
  logic tickSeen, lastSens;
  assign res = hpf_pkg::FREQ_DIVIDEND / {2'h0, halfPeriod};
  assign sum = {2'h0, h1} + {2'h0, h2} + {2'h0, h3} + {2'h0, res};
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      {h1, h2, h3, gap, sinceEdge, tickSeen, lastSens} <= '0;
    end else begin
      if (freqUpdate) begin
        {h3, h2, h1} <= {h2, h1, res};
      end
      lastSens <= sensorIn;
      // saturate so a long quiet sensor cannot wrap into the window
      if (sensorIn != lastSens) sinceEdge <= 8'h0;
      else if (sinceEdge != 8'hFF) sinceEdge <= sinceEdge + 8'h1;
      gap <= millisecondTick ? 16'h0 : gap + 16'h1;
      if (millisecondTick) tickSeen <= 1'b1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence sUpd; freqUpdate; endsequence
  sequence sTick; millisecondTick; endsequence
  a_init_value: assert property (measCount == 3'h0 |-> statorFreq == hpf_pkg::FREQ_INIT_VALUE)
    else $error("init value wrong");
  a_single_result: assert property (sUpd ##0 measCount < 3'h4 |-> statorFreq == res)
    else $error("single result wrong");
  a_avg_result: assert property (sUpd ##0 measCount == 3'h4 |-> statorFreq == sum[19:2])
    else $error("average wrong");
  a_count_step: assert property (sUpd |-> measCount ==
    (($past(measCount) == 3'h4) ? 3'h4 : $past(measCount) + 3'h1))
    else $error("count step wrong");
  a_hold_value: assert property (!freqUpdate |-> $stable(statorFreq) && $stable(measCount))
    else $error("estimate changed without update");
  a_tick_spacing: assert property (sTick ##0 tickSeen |-> gap == MS_TICK_CYCLES - 1)
    else $error("tick spacing wrong");
  a_ms_count: assert property (sTick |=>
    millisecondTimeCount == $past(millisecondTimeCount) + 16'h1)
    else $error("ms count not advanced");
  a_update_delay: assert property (sUpd |-> halfPeriod != 16'h0 &&
    sinceEdge >= 8'h12 && sinceEdge <= 8'h1A) else $error("update not tied to edge");
endmodule
bind hpf_estimator hpf_checker #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) hpf_checker_inst (
  .clock(clock), .rstn(rstn), .sensorIn(sensorIn), .statorFreq(statorFreq),
  .freqUpdate(freqUpdate), .measCount(measCount), .millisecondTick(millisecondTick),
  .millisecondTimeCount(millisecondTimeCount), .halfPeriod(halfPeriod));

/* verification/test_hall_period_freq_estimator.sv */
// Purpose: self-checking bench of the estimator
// Assumes: sensor gaps of k units plus half a unit, so counts are exact
// Notes: short ms prescaler keeps the run brief
`timescale 1ns/100ps
module test_hall_period_freq_estimator;
  localparam int MS = 50;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic req = 1'b0;
  logic [19:0] gap = 20'h0;
  logic sensorIn, ack, freqUpdate, millisecondTick;
  logic [17:0] statorFreq;
  logic [2:0] measCount;
  logic [15:0] millisecondTimeCount, halfPeriod, msMark;
  logic [17:0] hist [4];
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed = 83809;
  int n = 0;
  int ticks = 0;
  always #20 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 100000) begin
      errors++;
      test_done();
    end
  end
  hpf_estimator #(.MS_TICK_CYCLES(MS)) hpf_estimator_inst (.clock(clock), .rstn(rstn),
    .sensorIn(sensorIn), .statorFreq(statorFreq), .freqUpdate(freqUpdate),
    .measCount(measCount), .millisecondTick(millisecondTick),
    .millisecondTimeCount(millisecondTimeCount), .halfPeriod(halfPeriod));
  hpf_sensor_model hpf_sensor_model_inst (.clock(clock), .rstn(rstn), .req(req), .gap(gap),
    .ack(ack), .sensorIn(sensorIn));
  function automatic logic [17:0] expect_freq();
    logic [19:0] s;
    s = {2'h0, hist[0]} + {2'h0, hist[1]} + {2'h0, hist[2]} + {2'h0, hist[3]};
    if (n == 0) return hpf_pkg::FREQ_INIT_VALUE;
    if (n < 4) return hist[0];
    return s[19:2];
  endfunction
  task chk(input string name, input logic [17:0] exp, input logic [17:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task send(input int k, input bit take);
    int i;
    gap = 20'(k * 400 + 200);
    req = 1'b1;
    i = 0;
    while (ack !== 1'b1 && i < 20000) begin
      @(negedge clock);
      i++;
    end
    chk("ack", 18'h00001, {17'h0, ack});
    req = 1'b0;
    i = 0;
    while (freqUpdate !== 1'b1 && i < 40) begin
      @(negedge clock);
      i++;
    end
    chk("freqUpdate", {17'h0, take}, {17'h0, freqUpdate});
    if (take) begin
      hist[3] = hist[2];
      hist[2] = hist[1];
      hist[1] = hist[0];
      hist[0] = hpf_pkg::FREQ_DIVIDEND / 18'(k);
      if (n < 4) n++;
      chk("halfPeriod", 18'(k), {2'h0, halfPeriod});
    end
    chk("measCount", 18'(n), {15'h0, measCount});
    chk("statorFreq", expect_freq(), statorFreq);
  endtask
  task do_reset();
    rstn = 1'b0;
    repeat (6) @(negedge clock);
    rstn = 1'b1;
    n = 0;
    hist = '{default: 18'h0};
    chk("statorFreq", hpf_pkg::FREQ_INIT_VALUE, statorFreq);
  endtask
  task test_done();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    do_reset();
    send(3, 1'b0);
    send(1, 1'b1);
    // too short a gap gives a zero count and must be refused
    send(0, 1'b0);
    send(2, 1'b1);
    send(25, 1'b1);
    send(4, 1'b1);
    repeat (12) send(1 + int'($unsigned($random(seed)) % 12), 1'b1);
    msMark = millisecondTimeCount;
    // each tick pulse stands for one cycle, so it shows at exactly one falling edge
    repeat (3 * MS) begin
      @(negedge clock);
      if (millisecondTick === 1'b1) begin
        ticks++;
      end
    end
    chk("msTick", 18'h00003, 18'(ticks));
    chk("msCount", {2'h0, msMark + 16'h3}, {2'h0, millisecondTimeCount});
    do_reset();
    send(5, 1'b0);
    send(7, 1'b1);
    test_done();
  end
endmodule
